// ---- hw/gp_pkg.sv ----
// Function
// - Direction bits for ports A, C, D: 0 output, 1 input; reset all ones.
// - Port A data write loads output values; read returns sampled pin levels.
// - Port A is usable only when the host bus is narrow (HOST_NARROW high).
// - Port B bit 4 writes the keypad output pin, reads the keypad input pin.
// - Port B bits 3..0 read host strobe pins, valid only with serial host.
// - Port C bit 7 shares PWM 0; port C free only with PWM and flash off.
// - Port C bits 4..0 map to flash pins; write drives, read samples pins.
// - Port D bits map onto panel data lines; write drives, read returns pins.
// - Port D bits 5,4,1,0 free at 16/12-bit panel; 7,6,3,2 only at 16-bit.
package gp_pkg;

    localparam logic [7:0] IDX_A_DIR  = 8'hf0;
    localparam logic [7:0] IDX_A_DATA = 8'hf1;
    localparam logic [7:0] IDX_B_DATA = 8'hf2;
    localparam logic [7:0] IDX_C_DIR  = 8'hf3;
    localparam logic [7:0] IDX_C_DATA = 8'hf4;
    localparam logic [7:0] IDX_D_DIR  = 8'hf5;
    localparam logic [7:0] IDX_D_DATA = 8'hf6;

    localparam logic [7:0] DIR_RST    = 8'hff;
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [7:0] C_IMPL     = 8'h9f;
    localparam logic [7:0] D_FREE_12  = 8'h33;
    localparam logic [7:0] D_FREE_16  = 8'hff;
    localparam logic [7:0] NO_FREE    = 8'h00;
    localparam int         B_OUT_BIT  = 4;
    localparam int         PIN_W      = 29;

    typedef enum logic [1:0] {
        GP_PANEL_OTHER,
        GP_PANEL_12,
        GP_PANEL_16
    } gp_panel_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } gp_avm_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gp_drive_t;

endpackage

// ---- hw/gp_ports_top.sv ----
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
module gp_ports_top
    import gp_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // Avalon-MM slave
    input  wire gp_avm_req_t AVM_REQ,
    output logic [31:0]      AVM_READDATA,
    output logic             AVM_WAITREQUEST,
    // Shared-function configuration
    input  wire logic        HOST_NARROW,
    input  wire logic        HOST_SERIAL,
    input  wire logic        KEYPAD_EN,
    input  wire logic        PWM_EN,
    input  wire logic        FLASH_EN,
    input  wire gp_panel_t   PANEL_BUS,
    // Port A pins
    input  wire logic [7:0]  PA_IN,
    output gp_drive_t        PA_DRV,
    // Port B pins
    input  wire logic [4:0]  PB_IN,
    output logic             PB_OUT,
    output logic             PB_OE,
    // Port C pins
    input  wire logic [7:0]  PC_IN,
    output gp_drive_t        PC_DRV,
    // Port D pins
    input  wire logic [7:0]  PD_IN,
    output gp_drive_t        PD_DRV
);

    function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
        hit = (addr[9:2] == idx);
    endfunction

    function automatic logic [7:0] panel_free(input gp_panel_t w);
        if (w == GP_PANEL_16) begin
            panel_free = D_FREE_16;
        end else if (w == GP_PANEL_12) begin
            panel_free = D_FREE_12;
        end else begin
            panel_free = NO_FREE;
        end
    endfunction

    logic [7:0]       a_dir_q;
    logic [7:0]       a_data_q;
    logic             b_data_q;
    logic [7:0]       c_dir_q;
    logic [7:0]       c_data_q;
    logic [7:0]       d_dir_q;
    logic [7:0]       d_data_q;
    logic             wait_q;
    logic [31:0]      rdata_q;
    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic [7:0]       pa_lvl;
    logic [4:0]       pb_lvl;
    logic [7:0]       pc_lvl;
    logic [7:0]       pd_lvl;
    logic             req;
    logic             wr_ok;
    logic [7:0]       wdat;
    logic [7:0]       rd_d;
    logic [7:0]       a_free;
    logic [7:0]       c_free;
    logic [7:0]       d_free;

    assign req    = AVM_REQ.read | AVM_REQ.write;
    assign wr_ok  = AVM_REQ.write & ~wait_q & AVM_REQ.byteenable[0];
    assign wdat   = AVM_REQ.writedata[7:0];
    assign a_free = HOST_NARROW ? 8'hff : 8'h00;
    assign c_free = (PWM_EN | FLASH_EN) ? 8'h00 : C_IMPL;
    assign d_free = panel_free(PANEL_BUS);

    // Pins are asynchronous to CLK; stage one feeds stage two only
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {PA_IN, PB_IN, PC_IN, PD_IN};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign pa_lvl = pin_s2_q[28:21];
    assign pb_lvl = pin_s2_q[20:16];
    assign pc_lvl = pin_s2_q[15:8];
    assign pd_lvl = pin_s2_q[7:0];

    // One wait state: request seen with wait high, answered next cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_q <= 1'b1;
        end else if (req && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Direction registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            a_dir_q <= DIR_RST;
            c_dir_q <= DIR_RST;
            d_dir_q <= DIR_RST;
        end else if (wr_ok) begin
            if (hit(AVM_REQ.address, IDX_A_DIR)) begin
                a_dir_q <= wdat;
            end else if (hit(AVM_REQ.address, IDX_C_DIR)) begin
                c_dir_q <= wdat;
            end else if (hit(AVM_REQ.address, IDX_D_DIR)) begin
                d_dir_q <= wdat;
            end
        end
    end

    // Output data registers; values are kept even while not driven
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            a_data_q <= DATA_RST;
            b_data_q <= 1'b0;
            c_data_q <= DATA_RST;
            d_data_q <= DATA_RST;
        end else if (wr_ok) begin
            if (hit(AVM_REQ.address, IDX_A_DATA)) begin
                a_data_q <= wdat;
            end else if (hit(AVM_REQ.address, IDX_B_DATA)) begin
                b_data_q <= wdat[B_OUT_BIT];
            end else if (hit(AVM_REQ.address, IDX_C_DATA)) begin
                c_data_q <= wdat & C_IMPL;
            end else if (hit(AVM_REQ.address, IDX_D_DATA)) begin
                d_data_q <= wdat;
            end
        end
    end

    // Read decode; data registers return pin levels, not stored values
    always_comb begin
        rd_d = 8'h00;
        if (hit(AVM_REQ.address, IDX_A_DIR)) begin
            rd_d = a_dir_q;
        end else if (hit(AVM_REQ.address, IDX_A_DATA)) begin
            rd_d = pa_lvl;
        end else if (hit(AVM_REQ.address, IDX_B_DATA)) begin
            rd_d = {3'h0, pb_lvl[4], HOST_SERIAL ? pb_lvl[3:0] : 4'h0};
        end else if (hit(AVM_REQ.address, IDX_C_DIR)) begin
            rd_d = c_dir_q;
        end else if (hit(AVM_REQ.address, IDX_C_DATA)) begin
            rd_d = pc_lvl & C_IMPL;
        end else if (hit(AVM_REQ.address, IDX_D_DIR)) begin
            rd_d = d_dir_q;
        end else if (hit(AVM_REQ.address, IDX_D_DATA)) begin
            rd_d = pd_lvl;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= '0;
        end else if (AVM_REQ.read && wait_q) begin
            rdata_q <= {24'h0, rd_d};
        end
    end

    // Pin drivers, one cycle behind the registers so outputs are flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PA_DRV <= '0;
            PC_DRV <= '0;
            PD_DRV <= '0;
            PB_OUT <= 1'b0;
            PB_OE  <= 1'b0;
        end else begin
            PA_DRV.out <= a_data_q;
            PA_DRV.oe  <= a_free & ~a_dir_q;
            PC_DRV.out <= c_data_q;
            PC_DRV.oe  <= c_free & ~c_dir_q;
            PD_DRV.out <= d_data_q;
            PD_DRV.oe  <= d_free & ~d_dir_q;
            PB_OUT     <= b_data_q;
            PB_OE      <= ~KEYPAD_EN;
        end
    end

    assign AVM_READDATA    = rdata_q;
    assign AVM_WAITREQUEST = wait_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    property p_dir_input;
        (&a_dir_q) |=> (PA_DRV.oe == 8'h00);
    endproperty
    a_dir_input: assert property (p_dir_input)
        else $error("port A drives while all bits are inputs");

    property p_a_write;
        (wr_ok && hit(AVM_REQ.address, IDX_A_DATA))
            |=> (a_data_q == $past(wdat)) ##1 (PA_DRV.out == $past(a_data_q));
    endproperty
    a_a_write: assert property (p_a_write)
        else $error("port A write did not reach the pin output");

    property p_a_host;
        !HOST_NARROW |=> (PA_DRV.oe == 8'h00);
    endproperty
    a_a_host: assert property (p_a_host)
        else $error("port A drives while the host bus owns it");

    property p_b_read;
        (AVM_REQ.read && wait_q && hit(AVM_REQ.address, IDX_B_DATA))
            |=> (AVM_READDATA[7:4] == {3'h0, $past(pb_lvl[4])});
    endproperty
    a_b_read: assert property (p_b_read)
        else $error("port B bit 4 read does not match input pin");

    property p_b_strobes;
        (AVM_REQ.read && wait_q && !HOST_SERIAL && hit(AVM_REQ.address, IDX_B_DATA))
            |=> (AVM_READDATA[3:0] == 4'h0);
    endproperty
    a_b_strobes: assert property (p_b_strobes)
        else $error("host strobe bits visible without serial host");

    property p_c_shared;
        (PWM_EN || FLASH_EN) |=> (PC_DRV.oe == 8'h00);
    endproperty
    a_c_shared: assert property (p_c_shared)
        else $error("port C drives while PWM or flash is enabled");

    property p_c_read;
        (AVM_REQ.read && wait_q && hit(AVM_REQ.address, IDX_C_DATA))
            |=> (AVM_READDATA[7:0] == ($past(pc_lvl) & C_IMPL));
    endproperty
    a_c_read: assert property (p_c_read)
        else $error("port C read does not return pin levels");

    property p_d_out;
        PD_DRV.out == $past(d_data_q);
    endproperty
    a_d_out: assert property (p_d_out)
        else $error("port D output lags its data register wrongly");

    property p_d_width;
        (PANEL_BUS != GP_PANEL_16) |=> ((PD_DRV.oe & 8'hcc) == 8'h00);
    endproperty
    a_d_width: assert property (p_d_width)
        else $error("port D upper bits driven without 16-bit panel");

    property p_c_dir;
        (PC_DRV.oe != 8'h00) |-> (($past(c_dir_q) & PC_DRV.oe) == 8'h00);
    endproperty
    a_c_dir: assert property (p_c_dir)
        else $error("port C drives a bit set as input");

    property p_reserved;
        (AVM_REQ.read && wait_q && (AVM_REQ.address[9:2] > IDX_D_DATA))
            |=> (AVM_READDATA == 32'h0);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved address read not zero");

    property p_answer;
        (req && wait_q) |=> !AVM_WAITREQUEST ##1 AVM_WAITREQUEST;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer not after exactly one wait cycle");

    property p_wait_one;
        !AVM_WAITREQUEST |=> AVM_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");

    property p_rdata_hold;
        !(AVM_REQ.read && wait_q) |=> $stable(AVM_READDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a new read");

    property p_rdata_upper;
        AVM_READDATA[31:8] == 24'h0;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper)
        else $error("read data upper bytes not zero");

    property p_b_oe;
        PB_OE |-> !$past(KEYPAD_EN);
    endproperty
    a_b_oe: assert property (p_b_oe)
        else $error("keypad output pin driven while keypad owns it");

    property p_b_keypad;
        KEYPAD_EN |=> !PB_OE;
    endproperty
    a_b_keypad: assert property (p_b_keypad)
        else $error("keypad output pin still driven after keypad enable");

    property p_b_out;
        (wr_ok && hit(AVM_REQ.address, IDX_B_DATA))
            |=> ##1 (PB_OUT == $past(wdat[B_OUT_BIT], 2));
    endproperty
    a_b_out: assert property (p_b_out)
        else $error("port B bit 4 write did not reach the output pin");

    property p_a_dir_bits;
        (PA_DRV.oe & $past(a_dir_q)) == 8'h00;
    endproperty
    a_a_dir_bits: assert property (p_a_dir_bits)
        else $error("port A drives a bit set as input");

    property p_d_dir_bits;
        (PD_DRV.oe & $past(d_dir_q)) == 8'h00;
    endproperty
    a_d_dir_bits: assert property (p_d_dir_bits)
        else $error("port D drives a bit set as input");

    property p_c_unused;
        (PC_DRV.oe & 8'h60) == 8'h00;
    endproperty
    a_c_unused: assert property (p_c_unused)
        else $error("port C drives an unimplemented bit");

    property p_d_other;
        (PANEL_BUS == GP_PANEL_OTHER) |=> (PD_DRV.oe == 8'h00);
    endproperty
    a_d_other: assert property (p_d_other)
        else $error("port D drives while the panel bus owns it");

    property p_reserved_write;
        (wr_ok && (AVM_REQ.address[9:2] > IDX_D_DATA))
            |=> ($stable(a_dir_q) && $stable(c_dir_q) && $stable(d_dir_q));
    endproperty
    a_reserved_write: assert property (p_reserved_write)
        else $error("reserved address write changed a direction register");

    property p_a_read;
        (AVM_REQ.read && wait_q && hit(AVM_REQ.address, IDX_A_DATA))
            |=> (AVM_READDATA[7:0] == $past(pa_lvl));
    endproperty
    a_a_read: assert property (p_a_read)
        else $error("port A read does not return pin levels");

    property p_d_read;
        (AVM_REQ.read && wait_q && hit(AVM_REQ.address, IDX_D_DATA))
            |=> (AVM_READDATA[7:0] == $past(pd_lvl));
    endproperty
    a_d_read: assert property (p_d_read)
        else $error("port D read does not return pin levels");

endmodule

// ---- testbench/gp_pin_model.sv ----
`timescale 1ns/100ps
module gp_pin_model
    import gp_pkg::*;
(
    // From the block
    input  wire gp_drive_t  drv,
    // Level held by the other owner of an undriven pad
    input  wire logic [7:0] ext,
    // Pad level seen by everyone
    output logic [7:0]      pin
);
    // A pad follows the block only while its enable is high
    assign pin = (drv.oe & drv.out) | (~drv.oe & ext);
endmodule

// ---- testbench/shared_pin_gpio_ports_tb.sv ----
`timescale 1ns/100ps
module shared_pin_gpio_ports_tb
    import gp_pkg::*;
;
    logic        clk;
    logic        arst_n;
    gp_avm_req_t req;
    logic [31:0] rdata;
    logic        wreq;
    logic        host_narrow, host_serial, keypad_en, pwm_en, flash_en;
    gp_panel_t   panel;
    logic [4:0]  pb_in;
    logic        pb_out, pb_oe;
    gp_drive_t   pa_drv, pc_drv, pd_drv;
    logic [7:0]  pa_pin, pc_pin, pd_pin;
    logic [7:0]  pa_ext, pc_ext, pd_ext;
    logic [31:0] rv;
    logic [7:0]  dmask [3];
    int          num_errors;
    int          checked;

    gp_ports_top i_dut (.CLK(clk), .ARST_N(arst_n), .AVM_REQ(req), .AVM_READDATA(rdata),
        .AVM_WAITREQUEST(wreq), .HOST_NARROW(host_narrow), .HOST_SERIAL(host_serial),
        .KEYPAD_EN(keypad_en), .PWM_EN(pwm_en), .FLASH_EN(flash_en), .PANEL_BUS(panel),
        .PA_IN(pa_pin), .PA_DRV(pa_drv), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
        .PC_IN(pc_pin), .PC_DRV(pc_drv), .PD_IN(pd_pin), .PD_DRV(pd_drv));
    gp_pin_model i_pa (.drv(pa_drv), .ext(pa_ext), .pin(pa_pin));
    gp_pin_model i_pc (.drv(pc_drv), .ext(pc_ext), .pin(pc_pin));
    gp_pin_model i_pd (.drv(pd_drv), .ext(pd_ext), .pin(pd_pin));

    task automatic stop_test();
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic access(input logic is_wr, input logic [7:0] idx, input logic [7:0] wd,
                          input logic [3:0] be, output logic [31:0] rdv);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{read: !is_wr, write: is_wr, address: {idx, 2'b00}, byteenable: be,
                 writedata: {24'h0, wd}};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        rdv = rdata;
        req <= '0;
        if (wreq !== 1'b0) begin
            num_errors++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        access(1'b1, idx, d, 4'h1, rv);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        access(1'b0, idx, 8'h00, 4'h1, rv);
        chk(rv, {24'h0, exp});
    endtask

    // Covers register-to-pad lag plus the two-flop input synchroniser
    task automatic settle();
        repeat (5) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        req = '0;
        {host_narrow, host_serial, keypad_en, pwm_en, flash_en} = 5'h00;
        panel = GP_PANEL_OTHER;
        pb_in = 5'h00;
        pa_ext = 8'h3c;
        pc_ext = 8'h5a;
        pd_ext = 8'hc3;
        dmask = '{NO_FREE, D_FREE_12, D_FREE_16};
        num_errors = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk({24'h0, pa_drv.oe}, 32'h0);
        rd(IDX_A_DIR, DIR_RST);
        rd(IDX_D_DIR, DIR_RST);
        wr(8'hf8, 8'h55);
        rd(8'hf8, 8'h00);
        rd(8'hf7, 8'h00);
        rd(IDX_C_DIR, DIR_RST);
        host_narrow <= 1'b1;
        wr(IDX_A_DIR, 8'h00);
        wr(IDX_A_DATA, 8'ha5);
        settle();
        chk({16'h0, pa_drv.oe, pa_drv.out}, 32'hffa5);
        rd(IDX_A_DATA, 8'ha5);
        wr(IDX_A_DIR, 8'h0f);
        settle();
        chk({24'h0, pa_drv.oe}, 32'hf0);
        rd(IDX_A_DATA, 8'hac);
        // A write without byte lane 0 must leave the register alone
        access(1'b1, IDX_A_DATA, 8'h00, 4'h2, rv);
        settle();
        chk({24'h0, pa_drv.out}, 32'ha5);
        host_narrow <= 1'b0;
        settle();
        chk({24'h0, pa_drv.oe}, 32'h0);
        rd(IDX_A_DATA, 8'h3c);
        wr(IDX_B_DATA, 8'hff);
        pb_in <= 5'h1a;
        host_serial <= 1'b1;
        settle();
        chk({30'h0, pb_out, pb_oe}, 32'h3);
        rd(IDX_B_DATA, 8'h1a);
        host_serial <= 1'b0;
        keypad_en <= 1'b1;
        wr(IDX_B_DATA, 8'h00);
        settle();
        chk({30'h0, pb_out, pb_oe}, 32'h0);
        rd(IDX_B_DATA, 8'h10);
        wr(IDX_C_DIR, 8'h00);
        rd(IDX_C_DIR, 8'h00);
        wr(IDX_C_DATA, 8'hff);
        settle();
        chk({24'h0, pc_drv.oe}, {24'h0, C_IMPL});
        rd(IDX_C_DATA, C_IMPL);
        pwm_en <= 1'b1;
        settle();
        chk({24'h0, pc_drv.oe}, 32'h0);
        rd(IDX_C_DATA, 8'h1a);
        pwm_en <= 1'b0;
        flash_en <= 1'b1;
        settle();
        chk({24'h0, pc_drv.oe}, 32'h0);
        wr(IDX_D_DIR, 8'h00);
        wr(IDX_D_DATA, 8'hff);
        for (int i = 0; i < 3; i++) begin
            panel <= gp_panel_t'(i[1:0]);
            settle();
            chk({24'h0, pd_drv.oe}, {24'h0, dmask[i]});
            rd(IDX_D_DATA, dmask[i] | (pd_ext & ~dmask[i]));
        end
        wr(IDX_D_DATA, 8'h96);
        settle();
        rd(IDX_D_DATA, 8'h96);
        // Mid-run reset must bring every direction back to input
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk({24'h0, pd_drv.oe}, 32'h0);
        rd(IDX_D_DIR, DIR_RST);
        rd(IDX_C_DIR, DIR_RST);
        stop_test();
    end
endmodule
